// [uart_rx_status_pkg.sv]
// shared constants and types of the receive status block
package uart_rx_status_pkg;
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned BAUD_DEFAULT      = 115_200;
    localparam int unsigned OVERSAMPLE        = 16;
    localparam int unsigned FIFO_DEPTH        = 4;
    localparam int unsigned BAUD_DIV_DEFAULT  = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);

    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_RX_DATA        = 4'h1;
    localparam logic [3:0] ADDR_MODE           = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK       = 4'h4;

    localparam int unsigned BIT_ADDR_DETECT   = 5;
    localparam int unsigned BIT_RX_IDLE       = 4;
    localparam int unsigned BIT_PARITY_ERR    = 3;
    localparam int unsigned BIT_FRAMING_ERR   = 2;
    localparam int unsigned BIT_OVERRUN       = 1;
    localparam int unsigned BIT_DATA_AVAIL    = 0;

    localparam int unsigned BIT_MODE_NINE     = 0;
    localparam int unsigned BIT_MODE_PAR_EN   = 1;
    localparam int unsigned BIT_MODE_PAR_ODD  = 2;

    localparam int unsigned IRQ_RX_CHAR       = 0;
    localparam int unsigned IRQ_OVERRUN       = 1;
    localparam int unsigned IRQ_ERROR         = 2;
    localparam int unsigned IRQ_BITS          = 3;

    localparam logic [15:0] STATUS_RESET      = 16'h0010;
    localparam logic [2:0]  MODE_RESET        = 3'h0;
    localparam logic [2:0]  MASK_RESET        = 3'h0;

    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_t;
endpackage

// [uart_rx_shifter.sv]
// receive shift register: start, data, parity and stop sampling
`timescale 1ns/1ps
module uart_rx_shifter
    import uart_rx_status_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_tick,
    input  wire logic       i_flush,
    input  wire logic       i_rxd,
    input  wire logic       i_nine_bit,
    input  wire logic       i_parity_en,
    input  wire logic       i_parity_odd,
    output logic            o_busy,
    output logic            o_done,
    output logic [8:0]      o_data,
    output logic            o_parity_err,
    output logic            o_framing_err
);
    import uart_rx_status_pkg::*;

    rx_state_t   state_q;
    rx_state_t   state_d;
    logic [3:0]  phase_q;
    logic [3:0]  bit_q;
    logic [8:0]  shift_q;
    logic        par_q;
    logic        done_q;
    logic        par_err_q;
    logic        frm_err_q;

    wire mid_sample = i_tick && (phase_q == 4'h7);
    wire [3:0] data_bits = i_nine_bit ? 4'h9 : 4'h8;
    wire has_parity = i_parity_en && !i_nine_bit;
    wire [3:0] last_bit = has_parity ? data_bits : data_bits - 4'h1;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RX_IDLE:  if (i_tick && !i_rxd) state_d = RX_START;
            RX_START: if (mid_sample) state_d = i_rxd ? RX_IDLE : RX_DATA;
            RX_DATA:  if (mid_sample && bit_q == last_bit) state_d = RX_STOP;
            RX_STOP:  if (mid_sample) state_d = RX_IDLE;
            default:  state_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= RX_IDLE;
            phase_q <= 4'h0;
            bit_q   <= 4'h0;
            shift_q <= 9'h000;
            par_q   <= 1'b0;
            done_q  <= 1'b0;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
        end
        else if (i_flush)
        begin
            state_q <= RX_IDLE;
            phase_q <= 4'h0;
            bit_q   <= 4'h0;
            shift_q <= 9'h000;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_q  <= 1'b0;
            if (state_q == RX_IDLE)
            begin
                phase_q <= 4'h0;
                bit_q   <= 4'h0;
                par_q   <= i_parity_odd;
            end
            else if (i_tick)
            begin
                phase_q <= (phase_q == 4'h7 && state_q == RX_START) ? 4'h8 : phase_q + 4'h1;
            end
            if (state_q == RX_DATA && mid_sample)
            begin
                bit_q <= bit_q + 4'h1;
                par_q <= par_q ^ i_rxd;
                if (bit_q < data_bits)
                begin
                    shift_q <= i_nine_bit ? {i_rxd, shift_q[8:1]} : {1'b0, i_rxd, shift_q[7:1]};
                end
            end
            if (state_q == RX_STOP && mid_sample)
            begin
                done_q <= 1'b1;
                frm_err_q <= !i_rxd;
                par_err_q <= has_parity && par_q;
            end
        end
    end

    assign o_busy        = state_q != RX_IDLE;
    assign o_done        = done_q;
    assign o_data        = shift_q;
    assign o_parity_err  = par_err_q;
    assign o_framing_err = frm_err_q;
endmodule

// [uart_rx_fifo.sv]
// receive buffer with per-entry error bits, flip-flop storage
`timescale 1ns/1ps
module uart_rx_fifo
    import uart_rx_status_pkg::*;
#(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = FIFO_DEPTH
)
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic             i_flush,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic [WIDTH-1:0]      o_head,
    output logic                  o_empty,
    output logic                  o_full
);
    import uart_rx_status_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    wr_q;
    logic [AW:0]      cnt_q;

    wire do_pop  = i_pop && !o_empty;
    wire do_push = i_push && !o_full;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end
        else if (i_flush)
        begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
        end
    end

    generate
        for (genvar g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge i_ref_clk or posedge i_rst)
            begin
                if (i_rst)
                    mem_q[g] <= '0;
                else if (do_push && wr_q == AW'(g))
                    mem_q[g] <= i_data;
            end
        end
    endgenerate

    assign o_head  = mem_q[rd_q];
    assign o_empty = cnt_q == '0;
    assign o_full  = cnt_q == (AW + 1)'(DEPTH);
endmodule

// [uart_receive_status_logic.sv]
// receive status, error flags and register port of the serial receiver
// Behaviour
// - address characters: ninth bit set, nine-bit only
// - idle flag reads one when not receiving
// - parity flag describes character at buffer head
// - framing flag describes character at buffer head
// - overrun set on arrival into full buffer
// - clearing overrun empties buffer and shifter
// - data-available flag while buffer holds characters
`timescale 1ns/1ps
module uart_receive_status_logic
    import uart_rx_status_pkg::*;
#(
    parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT,
    parameter int unsigned DEPTH    = FIFO_DEPTH
)
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_rxd,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [15:0]      o_rdata,
    output logic             o_irq
);
    import uart_rx_status_pkg::*;

    localparam int unsigned DW = $clog2(BAUD_DIV + 1);

    logic        rxd_meta_q;
    logic        rxd_sync_q;
    logic [DW-1:0] div_q;
    logic        tick;
    logic        addr_en_q;
    logic        overrun_q;
    logic [2:0]  mode_q;
    logic [IRQ_BITS-1:0] irq_stat_q;
    logic [IRQ_BITS-1:0] irq_mask_q;
    logic [15:0] rdata_q;

    logic        busy;
    logic        done;
    logic [8:0]  rx_data;
    logic        rx_par_err;
    logic        rx_frame_err;
    logic [10:0] head;
    logic        empty;
    logic        full;

    // two-stage synchroniser on the line input
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rxd_meta_q <= 1'b1;
            rxd_sync_q <= 1'b1;
        end
        else
        begin
            rxd_meta_q <= i_rxd;
            rxd_sync_q <= rxd_meta_q;
        end
    end

    // oversampling tick divider
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            div_q <= '0;
        else if (div_q == DW'(BAUD_DIV - 1))
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end
    assign tick = div_q == DW'(BAUD_DIV - 1);

    wire wr_status  = i_wr && i_addr == ADDR_STATUS_CONTROL;
    wire wr_mode    = i_wr && i_addr == ADDR_MODE;
    wire wr_irq_clr = i_wr && i_addr == ADDR_IRQ_STATUS;
    wire wr_mask    = i_wr && i_addr == ADDR_IRQ_MASK;
    wire rd_data    = i_rd && i_addr == ADDR_RX_DATA;

    wire nine_bit   = mode_q[BIT_MODE_NINE];
    // software clears overrun by writing zero while it is set
    wire flush      = wr_status && overrun_q && !i_wdata[BIT_OVERRUN];

    // with address detect in nine-bit mode only address characters are kept
    wire is_address = nine_bit && rx_data[8];
    wire accept     = !(addr_en_q && nine_bit) || is_address;
    wire arrive     = done && accept;
    wire push       = arrive && !full && !overrun_q;
    wire overrun_ev = arrive && (full || overrun_q);

    uart_rx_shifter uart_rx_shifter_i
    (
        .i_ref_clk     (i_ref_clk),
        .i_rst         (i_rst),
        .i_tick        (tick),
        .i_flush       (flush),
        .i_rxd         (rxd_sync_q),
        .i_nine_bit    (nine_bit),
        .i_parity_en   (mode_q[BIT_MODE_PAR_EN]),
        .i_parity_odd  (mode_q[BIT_MODE_PAR_ODD]),
        .o_busy        (busy),
        .o_done        (done),
        .o_data        (rx_data),
        .o_parity_err  (rx_par_err),
        .o_framing_err (rx_frame_err)
    );

    // entries carry their own error bits so flags track the head
    uart_rx_fifo #(.WIDTH(11), .DEPTH(DEPTH)) uart_rx_fifo_i
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_flush   (flush),
        .i_push    (push),
        .i_data    ({rx_par_err, rx_frame_err, rx_data}),
        .i_pop     (rd_data),
        .o_head    (head),
        .o_empty   (empty),
        .o_full    (full)
    );

    wire parity_error_flag  = !empty && head[10];
    wire framing_error_flag = !empty && head[9];
    wire idle_flag          = !busy;
    wire avail              = !empty;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            overrun_q <= STATUS_RESET[BIT_OVERRUN];
        else if (overrun_ev)
            overrun_q <= 1'b1;
        else if (flush)
            overrun_q <= 1'b0;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            addr_en_q  <= STATUS_RESET[BIT_ADDR_DETECT];
            mode_q     <= MODE_RESET;
            irq_mask_q <= MASK_RESET;
        end
        else
        begin
            if (wr_status)
                addr_en_q <= i_wdata[BIT_ADDR_DETECT];
            if (wr_mode)
                mode_q <= i_wdata[2:0];
            if (wr_mask)
                irq_mask_q <= i_wdata[IRQ_BITS-1:0];
        end
    end

    wire [IRQ_BITS-1:0] irq_set;
    assign irq_set[IRQ_RX_CHAR] = push;
    assign irq_set[IRQ_OVERRUN] = overrun_ev;
    assign irq_set[IRQ_ERROR]   = push && (rx_par_err || rx_frame_err);

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_stat_q <= '0;
        else
            irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? i_wdata[IRQ_BITS-1:0] : '0)) | irq_set;
    end
    assign o_irq = |(irq_stat_q & irq_mask_q);

    wire [15:0] status_word = {10'h000, addr_en_q, idle_flag, parity_error_flag, framing_error_flag, overrun_q, avail};
    wire [15:0] rd_mux =
        (i_addr == ADDR_STATUS_CONTROL) ? status_word :
        (i_addr == ADDR_RX_DATA)        ? {7'h00, head[8:0] & {9{avail}}} :
        (i_addr == ADDR_MODE)           ? {13'h0000, mode_q} :
        (i_addr == ADDR_IRQ_STATUS)     ? {13'h0000, irq_stat_q} :
        (i_addr == ADDR_IRQ_MASK)       ? {13'h0000, irq_mask_q} :
                                          16'h0000;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata_q <= 16'h0000;
        else if (i_rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= 16'h0000;
    end
    assign o_rdata = rdata_q;
endmodule

// [uart_receive_status_logic_assertions.sv]
// port-level assertions of the receive status block
`timescale 1ns/1ps
module uart_rx_status_checker
    import uart_rx_status_pkg::*;
#(
    parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT
)
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_rxd,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] o_rdata,
    input  wire logic        o_irq
);
    // line high longer than any frame plus the input synchroniser
    localparam int QUIET = 12 * OVERSAMPLE * BAUD_DIV + 4;
    logic [15:0] high_cnt_q;
    logic        low_seen_q;
    logic        stat_rd_q;
    logic        ovr_q;
    wire         stat_rd = i_rd && (i_addr == ADDR_STATUS_CONTROL);
    // overrun as last read, including a read answered in this very cycle
    wire         ovr_seen = stat_rd_q ? o_rdata[BIT_OVERRUN] : ovr_q;
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            high_cnt_q <= 16'h0000;
            low_seen_q <= 1'b0;
            stat_rd_q  <= 1'b0;
            ovr_q      <= 1'b0;
        end
        else
        begin
            high_cnt_q <= !i_rxd ? 16'h0000 : high_cnt_q + {15'h0000, high_cnt_q != 16'hFFFF};
            low_seen_q <= low_seen_q || !i_rxd;
            stat_rd_q  <= stat_rd;
            ovr_q      <= ovr_seen;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    idle_when_quiet_a: assert property (stat_rd && high_cnt_q > QUIET |=> o_rdata[BIT_RX_IDLE])
        else $error("idle flag low on quiet line");
    empty_no_parity_a: assert property (stat_rd_q && !o_rdata[BIT_DATA_AVAIL] |-> !o_rdata[BIT_PARITY_ERR])
        else $error("parity flag with empty buffer");
    empty_no_framing_a: assert property (stat_rd_q && !o_rdata[BIT_DATA_AVAIL] |-> !o_rdata[BIT_FRAMING_ERR])
        else $error("framing flag with empty buffer");
    overrun_no_sw_a: assert property (stat_rd_q && !low_seen_q |-> !o_rdata[BIT_OVERRUN])
        else $error("overrun set without traffic");
    flush_empties_a: assert property ((i_wr && i_addr == ADDR_STATUS_CONTROL && !i_wdata[BIT_OVERRUN] && ovr_seen)
        ##1 stat_rd |=> !o_rdata[BIT_DATA_AVAIL] && !o_rdata[BIT_OVERRUN])
        else $error("overrun clear left data");
    empty_read_zero_a: assert property (stat_rd ##1 (!o_rdata[BIT_DATA_AVAIL] && i_rd && i_addr == ADDR_RX_DATA)
        |=> o_rdata == 16'h0000)
        else $error("empty data read not zero");
    mask_silences_a: assert property (i_wr && i_addr == ADDR_IRQ_MASK && i_wdata[2:0] == 3'h0 |=> !o_irq)
        else $error("interrupt high with zero mask");
endmodule

// [uart_line_model.sv]
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module uart_line_model
#(
    parameter int unsigned BIT_CLKS = 16
)
(
    input  wire logic i_ref_clk,
    output logic      o_rxd
);
    initial o_rxd = 1'b1;
    task automatic put_bit(input logic v);
        @(posedge i_ref_clk);
        o_rxd <= v;
        repeat (BIT_CLKS - 1) @(posedge i_ref_clk);
    endtask
    // start, data lsb first, optional parity, stop; line idles high after
    task automatic send(input logic [8:0] d, input int nb, input logic pon, input logic pbit, input logic stop);
        put_bit(1'b0);
        for (int i = 0; i < nb; i++)
            put_bit(d[i]);
        if (pon)
            put_bit(pbit);
        put_bit(stop);
        @(posedge i_ref_clk);
        o_rxd <= 1'b1;
    endtask
endmodule

// [uart_receive_status_logic_bench.sv]
// self-checking bench of the receive status block
`timescale 1ns/1ps
module uart_receive_status_logic_bench;
    import uart_rx_status_pkg::*;
    localparam int unsigned BDIV = 1;
    localparam logic [3:0]  ST = ADDR_STATUS_CONTROL;
    localparam logic [3:0]  DT = ADDR_RX_DATA;
    logic        i_ref_clk;
    logic        i_rst;
    logic        i_wr;
    logic        i_rd;
    logic [3:0]  i_addr;
    logic [15:0] i_wdata;
    wire  [15:0] o_rdata;
    wire         o_irq;
    logic        rxd;
    int          n_errors;
    int          samples_checked;
    uart_receive_status_logic #(.BAUD_DIV(BDIV), .DEPTH(FIFO_DEPTH)) uart_receive_status_logic_i
        (.i_ref_clk, .i_rst, .i_rxd(rxd), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq);
    uart_line_model #(.BIT_CLKS(OVERSAMPLE * BDIV)) uart_line_model_i (.i_ref_clk, .o_rxd(rxd));
    always #25 i_ref_clk = ~i_ref_clk;
    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        check($sformatf("register_%0h", a), o_rdata, e);
    endtask
    task automatic tx(input logic [8:0] d, input int nb, input logic pon, input logic pbit, input logic stop);
        uart_line_model_i.send(d, nb, pon, pbit, stop);
        repeat (40) @(posedge i_ref_clk);
        #1;
    endtask
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        complete_run;
    end
    initial
    begin
        i_ref_clk = 1'b0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        n_errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        rd(ST, STATUS_RESET);
        wr(ST, 16'h0022);
        rd(ST, 16'h0030);
        wr(ST, 16'h0000);
        fork
            tx(9'h05A, 8, 1'b0, 1'b0, 1'b1);
            begin
                repeat (64) @(posedge i_ref_clk);
                #1;
                rd(ST, 16'h0000);
            end
        join
        rd(ST, 16'h0011);
        rd(DT, 16'h005A);
        rd(ST, 16'h0010);
        wr(ADDR_IRQ_MASK, 16'h0004);
        wr(ADDR_MODE, 16'h0002);
        tx(9'h031, 8, 1'b1, ^8'h31, 1'b1);
        tx(9'h0C3, 8, 1'b1, ~^8'hC3, 1'b1);
        tx(9'h07E, 8, 1'b1, ^8'h7E, 1'b0);
        check("irq", {15'h0000, o_irq}, 16'h0001);
        rd(ST, 16'h0011);
        rd(DT, 16'h0031);
        rd(ST, 16'h0019);
        rd(DT, 16'h00C3);
        rd(ST, 16'h0015);
        rd(DT, 16'h007E);
        rd(ST, 16'h0010);
        rd(ADDR_IRQ_STATUS, 16'h0005);
        wr(ADDR_MODE, 16'h0006);
        tx(9'h031, 8, 1'b1, ~^8'h31, 1'b1);
        rd(ST, 16'h0011);
        rd(DT, 16'h0031);
        wr(ADDR_IRQ_STATUS, 16'h0007);
        rd(ADDR_IRQ_STATUS, 16'h0000);
        check("irq", {15'h0000, o_irq}, 16'h0000);
        wr(ADDR_MODE, 16'h0001);
        wr(ST, 16'h0020);
        tx(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
        tx(9'h055, 9, 1'b0, 1'b0, 1'b1);
        rd(ST, 16'h0031);
        rd(DT, 16'h01A5);
        rd(ST, 16'h0030);
        wr(ADDR_MODE, 16'h0000);
        tx(9'h055, 8, 1'b0, 1'b0, 1'b1);
        rd(DT, 16'h0055);
        wr(ST, 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h0002);
        for (int i = 0; i <= FIFO_DEPTH; i++)
            tx(9'(i + 1), 8, 1'b0, 1'b0, 1'b1);
        rd(ST, 16'h0013);
        check("irq", {15'h0000, o_irq}, 16'h0001);
        wr(ST, 16'h0000);
        rd(ST, 16'h0010);
        rd(DT, 16'h0000);
        wr(ADDR_IRQ_STATUS, 16'h0007);
        wr(ADDR_IRQ_MASK, 16'h0000);
        check("irq", {15'h0000, o_irq}, 16'h0000);
        repeat (200) @(posedge i_ref_clk);
        #1;
        rd(ST, 16'h0010);
        complete_run;
    end
endmodule
bind uart_receive_status_logic uart_rx_status_checker #(.BAUD_DIV(BAUD_DIV)) uart_rx_status_checker_i
    (.i_ref_clk, .i_rst, .i_rxd, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq);
